//--- bawp_consts.svh
// Constants of the broadcast-address and write-pointer front end.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef BAWP_CONSTS_SVH
`define BAWP_CONSTS_SVH

// Register map positions (seven-bit pointer values)
`define BAWP_OFS_FIRST_MODE     7'h00
`define BAWP_OFS_GROUP_ONE      7'h3a
`define BAWP_OFS_GROUP_TWO      7'h3b
`define BAWP_OFS_GROUP_THREE    7'h3c
`define BAWP_OFS_BROADCAST      7'h3d
`define BAWP_OFS_LAST_USED      7'h3e

// Wrap ranges of the automatic pointer step
`define BAWP_FULL_BASE          7'h00
`define BAWP_FULL_TOP           7'h3e
`define BAWP_BRIGHT_BASE        7'h0a
`define BAWP_BRIGHT_TOP         7'h21
`define BAWP_CTRL_BASE          7'h00
`define BAWP_CTRL_TOP           7'h39
`define BAWP_GRPBR_BASE         7'h08
`define BAWP_GRPBR_TOP          7'h21

// Field positions in the first mode register
`define BAWP_MODE_SCOPE_HIGH    6
`define BAWP_MODE_SCOPE_LOW     5
`define BAWP_MODE_GROUP_ONE_EN  3
`define BAWP_MODE_GROUP_TWO_EN  2
`define BAWP_MODE_GROUP_THR_EN  1
`define BAWP_MODE_BCAST_EN      0

// Field positions in the command byte
`define BAWP_CMD_FLAG_BIT       7

// Reset values
`define BAWP_RST_BROADCAST      8'he0
`define BAWP_RST_FIRST_MODE     8'h09
`define BAWP_RST_COMMAND        8'h00

// Bits per byte on the wire, the ninth clock is the ignored answer slot
`define BAWP_BITS_PER_BYTE      4'h8

`endif

//--- bawp_pkg.sv
// Types shared by the broadcast-address and write-pointer front end.
// Assumes bawp_consts.svh is on the include path.
package bawp_pkg;
    `include "bawp_consts.svh"

    // Transfer progress of the register front end
    typedef enum logic [2:0] {
        BAWP_IDLE,
        BAWP_ADDR,
        BAWP_CMD,
        BAWP_DATA,
        BAWP_SKIP
    } bawp_state_t;

    // Step range selected by the two scope bits
    typedef enum logic [1:0] {
        BAWP_SCOPE_FULL  = 2'h0,
        BAWP_SCOPE_BRIGHT = 2'h1,
        BAWP_SCOPE_CTRL  = 2'h2,
        BAWP_SCOPE_GRPBR = 2'h3
    } bawp_scope_t;
endpackage

//--- bawp_rx_if.sv
// Byte events passed from the wire receiver to the register front end.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface bawp_rx_if;
    logic       start;      // Start or repeated start seen
    logic       stop;       // Stop seen
    logic       byte_valid; // One received byte, one-cycle pulse
    logic [7:0] byte_data;  // Received byte, most significant bit first
    logic       first;      // Byte is the first after a start

    modport rx (
        output start,
        output stop,
        output byte_valid,
        output byte_data,
        output first
    );
    modport core (
        input  start,
        input  stop,
        input  byte_valid,
        input  byte_data,
        input  first
    );
endinterface

//--- bawp_rx.sv
// Receive-only two-wire deframer: start, stop and byte events.
// Assumes scl and sda are already synchronous to mclk_i and sampled well
// above the bus bit rate; no answer bit is ever driven.
`timescale 1ns/10ps
module bawp_rx
    import bawp_pkg::*;
(
    input  wire logic  mclk_i,
    input  wire logic  sys_rst_i,
    input  wire logic  scl_i,
    input  wire logic  sda_i,
    bawp_rx_if.rx      rx
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       first_pend;
    logic       scl_rise;
    logic       start_det;
    logic       stop_det;

    // Bus conditions from the previous and present samples
    assign scl_rise  = scl_i & ~scl_q;
    assign start_det = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;

    // Previous samples
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Bit counting and shifting; the ninth bit is skipped
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            first_pend <= 1'b0;
        end else if (start_det || stop_det) begin
            bit_cnt    <= 4'h0;
            first_pend <= start_det;
        end else if (scl_rise) begin
            if (bit_cnt == `BAWP_BITS_PER_BYTE) begin
                bit_cnt <= 4'h0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shift   <= {shift[6:0], sda_i};
                if (bit_cnt == `BAWP_BITS_PER_BYTE - 4'h1) begin
                    first_pend <= 1'b0;
                end
            end
        end
    end

    // Event outputs, registered
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rx.start      <= 1'b0;
            rx.stop       <= 1'b0;
            rx.byte_valid <= 1'b0;
            rx.byte_data  <= 8'h00;
            rx.first      <= 1'b0;
        end else begin
            rx.start      <= start_det;
            rx.stop       <= stop_det;
            rx.byte_valid <= 1'b0;
            if (!start_det && !stop_det && scl_rise
                && bit_cnt == `BAWP_BITS_PER_BYTE - 4'h1) begin
                rx.byte_valid <= 1'b1;
                rx.byte_data  <= {shift[6:0], sda_i};
                rx.first      <= first_pend;
            end
        end
    end
endmodule

//--- bawp_top.sv
// Broadcast and group address recognition with command pointer stepping.
// Assumes wire inputs synchronous to mclk_i; forwards register writes in
// the range up to the last used location to the rest of the device.
//
// Contract
// - Broadcast address loads E0h at reset, recognition on, software may rewrite it.
// - Three writable group addresses, all sharing one fixed reset value.
// - Only the first group address is recognised after reset; others wait.
// - Byte after any matched address is the command; later bytes are data.
// - Command low seven bits are the pointer, top bit the step flag.
// - Step range uses the flag and mode register bits six and five.
// - With the flag set, pointer advances after each written data byte.
// - Flag and scope all zero keep the pointer fixed.
// - Flag one, scope 00: step whole space, wrap after 3Eh to 00h.
// - Flag one, scope 01: brightness range, wrap after 21h to 0Ah.
// - Flag one, scope 10: control range, wrap after 39h to 00h.
// - Flag one, scope 11: group and brightness, wrap after 21h to 08h.
// - Stepping changes only the pointer bits; the flag keeps its value.
// - First data byte goes to the pointer's register, anywhere 00h to 3Eh.
// - Pointer below the range still counts upward, wrapping past the top.
// - Bytes for unused locations are dropped; pointer still steps.
// - Write-only: transfers with direction bit one are ignored.
`timescale 1ns/10ps
module bawp_top
    import bawp_pkg::*;
#(
    parameter logic [7:0] GROUP_ADDR_DEFAULT = 8'h9a // Value arbitrary
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    input  wire logic [6:0]  dev_addr_i,
    output logic             reg_wr_o,
    output logic [6:0]       reg_addr_o,
    output logic [7:0]       reg_data_o,
    output logic [6:0]       pointer_o,
    output logic             auto_step_flag_o,
    output logic             step_scope_high_o,
    output logic             step_scope_low_o,
    output logic [7:0]       broadcast_address_reg_o,
    output logic [7:0]       group_address_one_o,
    output logic [7:0]       group_address_two_o,
    output logic [7:0]       group_address_three_o,
    output logic             selected_o
);
    localparam int GROUPS = 3;

    bawp_rx_if      rx_bus ();
    bawp_state_t    state;
    logic [7:0]     write_pointer_command;
    logic [7:0]     first_mode_reg;
    logic [7:0]     broadcast_address_reg;
    logic [7:0]     group_addr [GROUPS];
    logic [GROUPS-1:0] group_en;
    logic [GROUPS-1:0] group_hit;
    logic [6:0]     group_ofs [GROUPS];
    logic           bcast_hit;
    logic           own_hit;
    logic           addr_match;
    logic           data_write;
    logic           loc_used;
    logic [6:0]     pointer;
    logic           auto_step_flag;
    logic           step_scope_high;
    logic           step_scope_low;
    bawp_scope_t    scope;
    logic [6:0]     range_base;
    logic [6:0]     range_top;
    logic [6:0]     next_pointer;

    // Wire deframer
    bawp_rx u_rx (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .rx        (rx_bus.rx)
    );

    // Command fields
    assign pointer        = write_pointer_command[6:0];
    assign auto_step_flag = write_pointer_command[`BAWP_CMD_FLAG_BIT];

    // Scope bits from the first mode register
    assign step_scope_high = first_mode_reg[`BAWP_MODE_SCOPE_HIGH];
    assign step_scope_low  = first_mode_reg[`BAWP_MODE_SCOPE_LOW];
    assign scope           = bawp_scope_t'({step_scope_high, step_scope_low});

    // Recognition enables held in the first mode register
    assign group_en[0] = first_mode_reg[`BAWP_MODE_GROUP_ONE_EN];
    assign group_en[1] = first_mode_reg[`BAWP_MODE_GROUP_TWO_EN];
    assign group_en[2] = first_mode_reg[`BAWP_MODE_GROUP_THR_EN];

    // Locations of the group address registers
    assign group_ofs[0] = `BAWP_OFS_GROUP_ONE;
    assign group_ofs[1] = `BAWP_OFS_GROUP_TWO;
    assign group_ofs[2] = `BAWP_OFS_GROUP_THREE;

    // Address comparison on the first byte after a start
    assign bcast_hit = first_mode_reg[`BAWP_MODE_BCAST_EN]
                     && rx_bus.byte_data[7:1] == broadcast_address_reg[7:1];
    assign own_hit   = rx_bus.byte_data[7:1] == dev_addr_i;
    assign addr_match = !rx_bus.byte_data[0]
                      && (own_hit || bcast_hit || |group_hit);

    // Data byte written in this cycle, and whether it lands on a used location
    assign data_write = state == BAWP_DATA && rx_bus.byte_valid && !rx_bus.first;
    assign loc_used   = pointer <= `BAWP_OFS_LAST_USED;

    // Wrap range per scope setting
    always_comb begin
        range_base = `BAWP_FULL_BASE;
        range_top  = `BAWP_FULL_TOP;
        case (scope)
            BAWP_SCOPE_FULL: begin
                range_base = `BAWP_FULL_BASE;
                range_top  = `BAWP_FULL_TOP;
            end
            BAWP_SCOPE_BRIGHT: begin
                range_base = `BAWP_BRIGHT_BASE;
                range_top  = `BAWP_BRIGHT_TOP;
            end
            BAWP_SCOPE_CTRL: begin
                range_base = `BAWP_CTRL_BASE;
                range_top  = `BAWP_CTRL_TOP;
            end
            default: begin
                range_base = `BAWP_GRPBR_BASE;
                range_top  = `BAWP_GRPBR_TOP;
            end
        endcase
    end

    // Pointer step: hold without the flag, else count up and wrap at the top
    always_comb begin
        if (!auto_step_flag) begin
            next_pointer = pointer;
        end else if (pointer == range_top) begin
            next_pointer = range_base;
        end else begin
            next_pointer = pointer + 7'h01;
        end
    end

    // Transfer sequencing
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state <= BAWP_IDLE;
        end else if (rx_bus.stop) begin
            state <= BAWP_IDLE;
        end else if (rx_bus.start) begin
            state <= BAWP_ADDR;
        end else if (rx_bus.byte_valid) begin
            case (state)
                BAWP_ADDR: begin
                    state <= addr_match ? BAWP_CMD : BAWP_SKIP;
                end
                BAWP_CMD: begin
                    state <= BAWP_DATA;
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Command register: loaded after a match, pointer bits stepped on data
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            write_pointer_command <= `BAWP_RST_COMMAND;
        end else if (state == BAWP_CMD && rx_bus.byte_valid && !rx_bus.start) begin
            write_pointer_command <= rx_bus.byte_data;
        end else if (data_write && !rx_bus.start && !rx_bus.stop) begin
            write_pointer_command[6:0] <= next_pointer;
        end
    end

    // Register write port toward the rest of the device
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            reg_wr_o   <= 1'b0;
            reg_addr_o <= 7'h00;
            reg_data_o <= 8'h00;
        end else begin
            reg_wr_o <= 1'b0;
            if (data_write && !rx_bus.start && !rx_bus.stop && loc_used) begin
                reg_wr_o   <= 1'b1;
                reg_addr_o <= pointer;
                reg_data_o <= rx_bus.byte_data;
            end
        end
    end

    // First mode register copy: scope and recognition enables
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            first_mode_reg <= `BAWP_RST_FIRST_MODE;
        end else if (data_write && !rx_bus.start && !rx_bus.stop
                     && pointer == `BAWP_OFS_FIRST_MODE) begin
            first_mode_reg <= rx_bus.byte_data;
        end
    end

    // Broadcast address register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            broadcast_address_reg <= `BAWP_RST_BROADCAST;
        end else if (data_write && !rx_bus.start && !rx_bus.stop
                     && pointer == `BAWP_OFS_BROADCAST) begin
            broadcast_address_reg <= rx_bus.byte_data;
        end
    end

    // Group address registers and their comparators, one per entry
    for (genvar g = 0; g < GROUPS; g++) begin : g_group
        always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
                group_addr[g] <= GROUP_ADDR_DEFAULT;
            end else if (data_write && !rx_bus.start && !rx_bus.stop
                         && pointer == group_ofs[g]) begin
                group_addr[g] <= rx_bus.byte_data;
            end
        end
        assign group_hit[g] = group_en[g]
                            && rx_bus.byte_data[7:1] == group_addr[g][7:1];
    end

    // Status outputs
    assign pointer_o               = pointer;
    assign auto_step_flag_o        = auto_step_flag;
    assign step_scope_high_o       = step_scope_high;
    assign step_scope_low_o        = step_scope_low;
    assign broadcast_address_reg_o = broadcast_address_reg;
    assign group_address_one_o     = group_addr[0];
    assign group_address_two_o     = group_addr[1];
    assign group_address_three_o   = group_addr[2];
    assign selected_o              = state == BAWP_CMD || state == BAWP_DATA;
endmodule

//--- bawp_top_chk.sv
// Concurrent checks on the ports of the broadcast and write-pointer front end.
// Assumes it is bound to bawp_top and sees only that module's ports.
`timescale 1ns/10ps
module bawp_top_chk
    import bawp_pkg::*;
#(
    parameter logic [7:0] GROUP_ADDR_DEFAULT = 8'h9a
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    input  wire logic [6:0]  dev_addr_i,
    input  wire logic        reg_wr_o,
    input  wire logic [6:0]  reg_addr_o,
    input  wire logic [7:0]  reg_data_o,
    input  wire logic [6:0]  pointer_o,
    input  wire logic        auto_step_flag_o,
    input  wire logic        step_scope_high_o,
    input  wire logic        step_scope_low_o,
    input  wire logic [7:0]  broadcast_address_reg_o,
    input  wire logic [7:0]  group_address_one_o,
    input  wire logic [7:0]  group_address_two_o,
    input  wire logic [7:0]  group_address_three_o,
    input  wire logic        selected_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Next pointer after a write with the flag set
    function automatic logic [6:0] step_of(input logic [6:0] p, input logic [1:0] s);
        logic [6:0] top;
        top = (s == 2'h0) ? 7'h3e : (s == 2'h2) ? 7'h39 : 7'h21;
        return (p != top) ? p + 7'h01 : (s == 2'h1) ? 7'h0a : (s == 2'h3) ? 7'h08 : 7'h00;
    endfunction

    // Register values seen right after reset
    rst_vals_a: assert property ($fell(sys_rst_i) |-> broadcast_address_reg_o == 8'he0 && {auto_step_flag_o, pointer_o} == 8'h00)
        else $error("reset value of broadcast or command wrong");
    grp_rst_a: assert property ($fell(sys_rst_i) |-> group_address_one_o == GROUP_ADDR_DEFAULT && group_address_two_o == GROUP_ADDR_DEFAULT && group_address_three_o == GROUP_ADDR_DEFAULT)
        else $error("group reset value wrong");
    // Write strobe shape and location
    wr_pulse_a: assert property (reg_wr_o |=> !reg_wr_o[*8])
        else $error("write strobe longer than one cycle");
    wr_range_a: assert property (reg_wr_o |-> reg_addr_o <= 7'h3e)
        else $error("write to unused location");
    wr_sel_a: assert property (reg_wr_o |-> selected_o)
        else $error("write outside a matched transfer");
    // Pointer behaviour around each write
    flag_keep_a: assert property (reg_wr_o |-> $stable(auto_step_flag_o))
        else $error("step flag changed by a write");
    step_wrap_a: assert property (reg_wr_o && auto_step_flag_o && reg_addr_o != 7'h00 |-> pointer_o == step_of(reg_addr_o, {step_scope_high_o, step_scope_low_o}))
        else $error("pointer step wrong");
    step_hold_a: assert property (reg_wr_o && !auto_step_flag_o && !step_scope_high_o && !step_scope_low_o && reg_addr_o != 7'h00 |-> pointer_o == reg_addr_o)
        else $error("pointer moved without flag");
    ptr_cause_a: assert property ($changed(pointer_o) |-> selected_o)
        else $error("pointer changed outside a transfer");

    cover property (reg_wr_o && auto_step_flag_o && pointer_o == 7'h0a);
    cover property (reg_wr_o && reg_addr_o == 7'h3e);
    cover property ($rose(selected_o));
endmodule

//--- bawp_master.sv
// Write-only two-wire bus master model with start, stop and byte tasks.
// Assumes the caller sits on mclk_i; released data reads high through a pull-up.
`timescale 1ns/10ps
module bawp_master (
    input  wire logic  mclk_i,
    output logic       scl_o,
    output logic       sda_o
);
    localparam int H = 3; // Cycles each line level is held

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Set both lines just after an edge, then hold them
    task automatic lv(input logic c, input logic d);
        scl_o = c;
        sda_o = d;
        repeat (H) @(posedge mclk_i);
        #2;
    endtask

    // Start, also usable as a repeated start
    task automatic start_c();
        lv(scl_o, 1'b1);
        lv(1'b1, 1'b1);
        lv(1'b1, 1'b0);
        lv(1'b0, 1'b0);
    endtask

    task automatic stop_c();
        lv(1'b0, 1'b0);
        lv(1'b1, 1'b0);
        lv(1'b1, 1'b1);
    endtask

    // Eight bits first high, then a released answer slot
    task automatic byte_c(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            lv(1'b0, b[i]);
            lv(1'b1, b[i]);
        end
        lv(1'b0, 1'b1);
        lv(1'b1, 1'b1);
        lv(1'b0, 1'b1);
    endtask
endmodule

//--- bawp_top_tb.sv
// Self-checking bench for the broadcast and write-pointer front end.
// Assumes the bus master model drives the wire and writes are scored from a queue.
`timescale 1ns/10ps
module bawp_top_tb;
    import bawp_pkg::*;
    logic        mclk_i;
    logic        sys_rst_i;
    logic        scl_i;
    logic        sda_i;
    logic [6:0]  dev_addr_i;
    logic        reg_wr_o;
    logic [6:0]  reg_addr_o;
    logic [7:0]  reg_data_o;
    logic [6:0]  pointer_o;
    logic        auto_step_flag_o;
    logic        step_scope_high_o;
    logic        step_scope_low_o;
    logic [7:0]  broadcast_address_reg_o;
    logic [7:0]  group_address_one_o;
    logic [7:0]  group_address_two_o;
    logic [7:0]  group_address_three_o;
    logic        selected_o;
    logic [14:0] exp_q[$];
    logic [1:0]  scope_m = 2'h0;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [6:0]  starts [4] = '{7'h3d, 7'h20, 7'h38, 7'h20};

    bawp_top i_bawp_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
        .dev_addr_i(dev_addr_i), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
        .reg_data_o(reg_data_o), .pointer_o(pointer_o), .auto_step_flag_o(auto_step_flag_o),
        .step_scope_high_o(step_scope_high_o), .step_scope_low_o(step_scope_low_o),
        .broadcast_address_reg_o(broadcast_address_reg_o),
        .group_address_one_o(group_address_one_o), .group_address_two_o(group_address_two_o),
        .group_address_three_o(group_address_three_o), .selected_o(selected_o));
    bawp_master i_bawp_master (.mclk_i(mclk_i), .scl_o(scl_i), .sda_o(sda_i));

    // Clock and hang limit
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_wr(input logic [14:0] e, input logic [14:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR write expected %h seen %h", e, g);
        end
    endtask

    // Scoreboard: each write strobe takes the oldest expected write
    always @(negedge mclk_i) begin
        if (reg_wr_o !== 1'b0) begin
            if (exp_q.size() == 0) chk_wr(15'h7fff, {reg_addr_o, reg_data_o});
            else chk_wr(exp_q.pop_front(), {reg_addr_o, reg_data_o});
        end
    end

    // Expected pointer step of the reference model
    function automatic logic [6:0] nxt(input logic [6:0] p, input logic [1:0] s);
        logic [6:0] top;
        top = (s == 2'h0) ? 7'h3e : (s == 2'h2) ? 7'h39 : 7'h21;
        return (p != top) ? p + 7'h01 : (s == 2'h1) ? 7'h0a : (s == 2'h3) ? 7'h08 : 7'h00;
    endfunction

    // One write transfer; hit says whether the device should take it
    task automatic xfer(input logic [7:0] adr, input logic [7:0] cmd, input int n, input bit hit,
                        input logic [7:0] d0);
        logic [6:0] p;
        logic [7:0] d;
        p = cmd[6:0];
        d = d0;
        i_bawp_master.start_c();
        i_bawp_master.byte_c(adr);
        i_bawp_master.byte_c(cmd);
        for (int i = 0; i < n; i++) begin
            if (hit && p <= 7'h3e) exp_q.push_back({p, d});
            if (hit && p == 7'h00) scope_m = d[6:5];
            if (hit && cmd[7]) p = nxt(p, scope_m);
            i_bawp_master.byte_c(d);
            d = 8'($urandom);
        end
        i_bawp_master.stop_c();
        if (hit) chk8("command", {cmd[7], p}, {auto_step_flag_o, pointer_o});
        chk8("pending", 8'h00, 8'(exp_q.size()));
    endtask

    task automatic final_report();
        $display("TB: checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst_i = 1'b1;
        dev_addr_i = 7'h15; // Own address kept off E0h and the group default
        void'($urandom(32'h0e6e));
        repeat (4) @(posedge mclk_i);
        #2;
        sys_rst_i = 1'b0;
        chk8("broadcast", 8'he0, broadcast_address_reg_o);
        chk8("group one", 8'h9a, group_address_one_o);
        chk8("group three", 8'h9a, group_address_three_o);
        chk8("command", 8'h00, {auto_step_flag_o, pointer_o});
        $display("TB: reset test done");
        xfer(8'h2a, 8'h05, 2, 1'b1, 8'($urandom));
        $display("TB: fixed pointer test done");
        // Each scope: mode write, then two bytes across the range top
        for (int s = 0; s < 4; s++) begin
            xfer(8'h2a, 8'h80, 1, 1'b1, {1'b0, 2'(s), 5'h09});
            chk8("scope", 8'(s), {6'h00, step_scope_high_o, step_scope_low_o});
            xfer(8'h2a, {1'b1, starts[s]}, 2, 1'b1, (s == 0) ? 8'hc5 : 8'($urandom));
        end
        chk8("broadcast", 8'hc5, broadcast_address_reg_o);
        $display("TB: wrap test done");
        xfer(8'h2a, 8'h80, 1, 1'b1, 8'h29);
        xfer(8'h2a, 8'h85, 2, 1'b1, 8'($urandom));
        xfer(8'h2a, 8'hfe, 2, 1'b1, 8'($urandom));
        xfer(8'h2b, 8'h05, 1, 1'b0, 8'($urandom));
        $display("TB: range and read test done");
        xfer(8'h2a, 8'hbb, 1, 1'b1, 8'hb4);
        chk8("group two", 8'hb4, group_address_two_o);
        xfer(8'hb4, 8'h05, 1, 1'b0, 8'($urandom));
        xfer(8'h9a, 8'h8a, 2, 1'b1, 8'($urandom));
        xfer(8'hc4, 8'h8c, 1, 1'b1, 8'($urandom));
        $display("TB: address match test done");
        final_report();
    end
endmodule

bind bawp_top bawp_top_chk #(.GROUP_ADDR_DEFAULT(GROUP_ADDR_DEFAULT)) i_bawp_top_chk (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .dev_addr_i(dev_addr_i), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
    .reg_data_o(reg_data_o), .pointer_o(pointer_o), .auto_step_flag_o(auto_step_flag_o),
    .step_scope_high_o(step_scope_high_o), .step_scope_low_o(step_scope_low_o),
    .broadcast_address_reg_o(broadcast_address_reg_o), .group_address_one_o(group_address_one_o),
    .group_address_two_o(group_address_two_o), .group_address_three_o(group_address_three_o),
    .selected_o(selected_o));
